// file: cwd_params.svh
// constants for the core wrapper instruction decode block
`ifndef CWD_PARAMS_SVH
`define CWD_PARAMS_SVH

// instruction register width and opcodes
`define CWD_IR_W         3
`define CWD_OP_BYPASS    3'h0
`define CWD_OP_EXTEST    3'h1
`define CWD_OP_INTEST    3'h2
`define CWD_OP_PEXTEST   3'h3

// value loaded into the instruction shift stage on a capture event
`define CWD_IR_CAPT      3'h1

// boundary register layout: input cells low, output cells high
`define CWD_NIN          4
`define CWD_NOUT         4
`define CWD_BR_LEN       8
`define CWD_IN_LSB       0
`define CWD_OUT_LSB      4

// serial path lengths per instruction
`define CWD_LEN_BYPASS   4'h1
`define CWD_LEN_BOUNDARY 4'h8

`endif

// file: cwd_pkg.sv
// types shared by the core wrapper instruction decode block
package cwd_pkg;
`include "cwd_params.svh"

   typedef enum logic [1:0] {
      MODE_BYPASS,
      MODE_EXTEST,
      MODE_INTEST,
      MODE_PEXTEST
   } cwd_mode_t;

   // serial control and data pins that come from outside the clock domain
   typedef struct packed {
      logic                 wrck;
      logic                 wrst_n;
      logic                 wsi;
      logic                 sel_wir;
      logic                 shift;
      logic                 capture;
      logic                 update;
      logic                 wpi;
      logic [`CWD_NIN-1:0]  pin_in;
   } cwd_pins_t;

endpackage

// file: cwd_tam_model.sv
// serial test controller model that drives the wrapper control pins
`timescale 1ns/100ps
module cwd_tam_model (
   input  wire logic clk,
   output logic      wrck,
   output logic      wrst_n,
   output logic      wsi,
   output logic      sel_wir,
   output logic      shift_wr,
   output logic      capture_wr,
   output logic      update_wr
);
   initial begin
      wrck = 1'b0;
      wrst_n = 1'b1;
      wsi = 1'b0;
      sel_wir = 1'b0;
      shift_wr = 1'b0;
      capture_wr = 1'b0;
      update_wr = 1'b0;
   end
   // one 80 ns wrck cycle per op; controls lead the rise by 3 clk and wrck rests low
   task automatic op(input logic s, input logic sh, input logic cp, input logic up,
                     input logic d);
      @(posedge clk);
      sel_wir    <= s;
      shift_wr   <= sh;
      capture_wr <= cp;
      update_wr  <= up;
      // an idle data line toggles so a stale bit never passes for data
      wsi        <= sh ? d : ~wsi;
      repeat (3) @(posedge clk);
      wrck <= 1'b1;
      repeat (5) @(posedge clk);
      wrck <= 1'b0;
      @(posedge clk);
   endtask
   // lsb goes in first, then one update op
   task automatic load_ir(input logic [2:0] code);
      for (int i = 0; i < 3; i++)
         op(1'b1, 1'b1, 1'b0, 1'b0, code[i]);
      op(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
   endtask
   task automatic wreset();
      @(posedge clk);
      wrst_n <= 1'b0;
      repeat (5) @(posedge clk);
      wrst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
endmodule

// file: cwd_wrapper_decode.sv
// wrapper instruction register, decode, bypass and boundary register
//
// What this block does
// - serial instructions move test data only through the serial port
// - the parallel instruction moves its test data only through the parallel port
// - under the parallel instruction the bypass bit sits between serial in and out
// - an inward-facing core test instruction is decoded
// - bypass and serial external test each decode from their own opcode
// - every standard instruction has its own opcode, chosen freely
// - a user instruction sharing an opcode behaves as that standard one
// - bypass is in effect whenever the wrapper is disabled
// - under bypass only the one-bit bypass register is in the serial path
// - under bypass wrapper activity never disturbs the core
// - under bypass every boundary cell passes its functional signal through
// - wrapper reset makes bypass the active instruction
// - serial control signals sequence bypass and serial external test
// - under serial external test only the boundary register is in the path
// - under serial external test the core is protected by a hold
// - under serial external test outputs come from held cell data after update
// - under serial external test capture loads the input terminals
// - under serial external test capture leaves functional outputs alone
// - under serial external test the boundary register faces outward
// - under serial external test the core is kept quiet
// - under serial external test outputs stay at safe held values during shift
// - each instruction has a fixed serial path length
// - boundary data is held until a later instruction uses it
// - unselected registers stay still and disturb nothing
`timescale 1ns/100ps

module cwd_wrapper_decode
   import cwd_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 ce,
   input  wire logic                 wrck,
   input  wire logic                 wrst_n,
   input  wire logic                 wsi,
   input  wire logic                 sel_wir,
   input  wire logic                 shift_wr,
   input  wire logic                 capture_wr,
   input  wire logic                 update_wr,
   input  wire logic                 wpi,
   input  wire logic [`CWD_NIN-1:0]  pin_in,
   input  wire logic [`CWD_NOUT-1:0] core_out,
   output logic                      wso,
   output logic                      wpo,
   output logic      [`CWD_NOUT-1:0] wfo,
   output logic      [`CWD_NIN-1:0]  cfi,
   output logic                      core_hold,
   output logic                      par_en,
   output cwd_mode_t                 mode,
   output logic      [3:0]           path_len
);

   // unknown opcodes fall back to bypass, the only mode that leaves the core alone
   function automatic cwd_mode_t decode_op(input logic [`CWD_IR_W-1:0] op);
      cwd_mode_t m;
      m = MODE_BYPASS;
      unique case (op)
         `CWD_OP_BYPASS:  m = MODE_BYPASS;
         `CWD_OP_EXTEST:  m = MODE_EXTEST;
         `CWD_OP_INTEST:  m = MODE_INTEST;
         `CWD_OP_PEXTEST: m = MODE_PEXTEST;
         default:         m = MODE_BYPASS;
      endcase
      return m;
   endfunction

   function automatic logic faces_out(input cwd_mode_t m);
      return (m == MODE_EXTEST) || (m == MODE_PEXTEST);
   endfunction

   function automatic logic bypass_on_serial(input cwd_mode_t m);
      return (m == MODE_BYPASS) || (m == MODE_PEXTEST);
   endfunction

   cwd_pins_t                  pins_raw;
   cwd_pins_t                  pin_s1;
   cwd_pins_t                  pin_s2;
   logic                       wrck_d;
   logic                       wrck_rise;
   logic                       ir_ev;
   logic                       dr_ev;
   logic                       dr_cap;
   logic [`CWD_IR_W-1:0]       wir_sr;
   cwd_mode_t                  active;
   logic                       byp;
   logic [`CWD_BR_LEN-1:0]     br_sh;
   logic [`CWD_BR_LEN-1:0]     br_up;
   logic                       br_sel;
   logic                       br_sin;

   assign pins_raw = {wrck, wrst_n, wsi, sel_wir, shift_wr, capture_wr, update_wr, wpi, pin_in};

   // two-flop synchroniser on every pin; only pin_s2 is read by logic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else if (ce) begin
         pin_s1 <= pins_raw;
         pin_s2 <= pin_s1;
      end
   end

   // the wrapper clock is sampled, not used as a clock; it must stay slower than clk/4
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrck_d <= 1'b0;
      end else if (ce) begin
         wrck_d <= pin_s2.wrck;
      end
   end

   assign wrck_rise = pin_s2.wrck & ~wrck_d;
   assign ir_ev     = wrck_rise & pin_s2.wrst_n & pin_s2.sel_wir;
   assign dr_ev     = wrck_rise & pin_s2.wrst_n & ~pin_s2.sel_wir;
   assign dr_cap    = dr_ev & pin_s2.capture;
   assign br_sel    = (active != MODE_BYPASS);
   assign br_sin    = (active == MODE_PEXTEST) ? pin_s2.wpi : pin_s2.wsi;

   // instruction register: shift stage plus the decoded active instruction
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wir_sr <= `CWD_OP_BYPASS;
         active <= MODE_BYPASS;
      end else if (ce) begin
         if (!pin_s2.wrst_n) begin
            wir_sr <= `CWD_OP_BYPASS;
            active <= MODE_BYPASS;
         end else if (ir_ev) begin
            if (pin_s2.capture) begin
               wir_sr <= `CWD_IR_CAPT;
            end else if (pin_s2.shift) begin
               wir_sr <= {pin_s2.wsi, wir_sr[`CWD_IR_W-1:1]};
            end else if (pin_s2.update) begin
               active <= decode_op(wir_sr);
            end
         end
      end
   end

   // bypass bit moves only while it is the selected serial path
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         byp <= 1'b0;
      end else if (ce && dr_ev && bypass_on_serial(active)) begin
         if (pin_s2.capture) begin
            byp <= 1'b0;
         end else if (pin_s2.shift) begin
            byp <= pin_s2.wsi;
         end
      end
   end

   // boundary shift stage: outward capture takes the pins, inward the core outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         br_sh <= '0;
      end else if (ce && dr_ev && br_sel) begin
         if (pin_s2.capture) begin
            if (faces_out(active)) begin
               br_sh[`CWD_IN_LSB +: `CWD_NIN] <= pin_s2.pin_in;
            end else begin
               br_sh[`CWD_OUT_LSB +: `CWD_NOUT] <= core_out;
            end
         end else if (pin_s2.shift) begin
            br_sh <= {br_sin, br_sh[`CWD_BR_LEN-1:1]};
         end
      end
   end

   // update stage holds its data across instruction changes, so preloaded
   // values survive until the instruction that applies them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         br_up <= '0;
      end else if (ce && dr_ev && br_sel && pin_s2.update && !pin_s2.capture
                   && !pin_s2.shift) begin
         br_up <= br_sh;
      end
   end

   // serial and parallel scan outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wso <= 1'b0;
         wpo <= 1'b0;
      end else if (ce) begin
         if (pin_s2.sel_wir) begin
            wso <= wir_sr[0];
         end else if (bypass_on_serial(active)) begin
            wso <= byp;
         end else begin
            wso <= br_sh[0];
         end
         wpo <= (active == MODE_PEXTEST) ? br_sh[0] : 1'b0;
      end
   end

   // functional outputs: held cell data when facing out, core data otherwise.
   // shifting only touches br_sh, so outputs keep safe held values while shifting
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wfo <= '0;
      end else if (ce) begin
         if (faces_out(active)) begin
            wfo <= br_up[`CWD_OUT_LSB +: `CWD_NOUT];
         end else begin
            wfo <= core_out;
         end
      end
   end

   // core inputs: driven from cells only when testing inward
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfi <= '0;
      end else if (ce) begin
         if (active == MODE_INTEST) begin
            cfi <= br_up[`CWD_IN_LSB +: `CWD_NIN];
         end else begin
            cfi <= pin_s2.pin_in;
         end
      end
   end

   // status and core protection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_hold <= 1'b0;
         par_en    <= 1'b0;
         mode      <= MODE_BYPASS;
         path_len  <= `CWD_LEN_BYPASS;
      end else if (ce) begin
         core_hold <= faces_out(active);
         par_en    <= (active == MODE_PEXTEST);
         mode      <= active;
         path_len  <= bypass_on_serial(active) ? `CWD_LEN_BYPASS
                                               : `CWD_LEN_BOUNDARY;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_reset_bypass: assert property (ce && !pin_s2.wrst_n |=> active == MODE_BYPASS)
      else $error("wrapper reset did not select bypass");

   a_ir_stable: assert property (
      (ce && pin_s2.wrst_n && !(ir_ev && pin_s2.update)) |=> $stable(active))
      else $error("active instruction changed without an update");

   a_byp_pass: assert property (ce && active == MODE_BYPASS |=> wfo == $past(core_out))
      else $error("bypass did not pass functional outputs");

   a_byp_nohold: assert property (ce && active == MODE_BYPASS |=> !core_hold)
      else $error("core held during bypass");

   a_ext_hold: assert property (ce && active == MODE_EXTEST |=> core_hold)
      else $error("core not protected in external test");

   a_ext_wfo: assert property (
      ce && active == MODE_EXTEST |=> wfo == $past(br_up[`CWD_OUT_LSB +: `CWD_NOUT]))
      else $error("external test output not from held cell");

   a_cap_wfo: assert property (
      (ce && active == MODE_EXTEST && dr_cap) ##1 (ce && active == MODE_EXTEST)
      |=> $stable(wfo))
      else $error("capture disturbed functional outputs");

   a_cap_pins: assert property (
      ce && active == MODE_EXTEST && dr_cap
      |=> br_sh[`CWD_IN_LSB +: `CWD_NIN] == $past(pin_s2.pin_in))
      else $error("capture did not load input terminals");

   a_byp_path: assert property (
      ce && active == MODE_BYPASS && !pin_s2.sel_wir |=> wso == $past(byp))
      else $error("bypass path not on serial out");

   a_par_path: assert property (
      ce && active == MODE_PEXTEST && !pin_s2.sel_wir |=> wso == $past(byp) && par_en)
      else $error("parallel instruction without bypass on serial path");

   a_ser_nopar: assert property (
      ce && active != MODE_PEXTEST |=> !par_en && !wpo)
      else $error("serial instruction used the parallel port");

   a_len_fix: assert property (
      ce && $stable(active) ##1 ce && $stable(active) |-> $stable(path_len))
      else $error("path length changed within an instruction");

   a_ext_path: assert property (
      ce && active == MODE_EXTEST && !pin_s2.sel_wir |=> wso == $past(br_sh[0]))
      else $error("boundary register not on serial out in external test");

   a_ext_shift: assert property (
      ce && active == MODE_EXTEST && dr_ev && pin_s2.shift && !pin_s2.capture
      |=> br_sh == {$past(pin_s2.wsi), $past(br_sh[`CWD_BR_LEN-1:1])})
      else $error("boundary shift did not take serial in");

   a_ext_outward: assert property (
      ce && active == MODE_EXTEST && dr_cap
      |=> br_sh[`CWD_OUT_LSB +: `CWD_NOUT] == $past(br_sh[`CWD_OUT_LSB +: `CWD_NOUT]))
      else $error("outward capture touched the output cells");

   a_ext_len: assert property (
      ce && active == MODE_EXTEST |=> path_len == `CWD_LEN_BOUNDARY)
      else $error("external test path length wrong");

   a_upd_only: assert property (
      ce && !(dr_ev && pin_s2.update) |=> $stable(br_up))
      else $error("held cell data changed without an update");

   a_byp_idle: assert property (ce && active == MODE_BYPASS |=> $stable(br_sh))
      else $error("boundary register moved during bypass");

   a_unsel_byp: assert property (
      ce && (active == MODE_EXTEST || active == MODE_INTEST) |=> $stable(byp))
      else $error("bypass bit moved while not selected");

   a_int_cfi: assert property (
      ce && active == MODE_INTEST |=> cfi == $past(br_up[`CWD_IN_LSB +: `CWD_NIN]))
      else $error("inward test did not drive core inputs from cells");

   a_wir_out: assert property (ce && pin_s2.sel_wir |=> wso == $past(wir_sr[0]))
      else $error("instruction register not on serial out");

   a_par_wpo: assert property (
      ce && active == MODE_PEXTEST |=> wpo == $past(br_sh[0]))
      else $error("parallel out not from boundary register");

   // clock enable low must leave every register as it was
   a_ce_freeze: assert property (
      !ce |=> $stable(active) && $stable(br_sh) && $stable(br_up) && $stable(wso))
      else $error("state moved while clock enable was low");

   c_enter_ext: cover property (ir_ev && pin_s2.update ##1 active == MODE_EXTEST);
   c_byp_shift: cover property (dr_ev && pin_s2.shift && active == MODE_BYPASS);
   c_ext_cap:   cover property (dr_cap && active == MODE_EXTEST);
   c_par_shift: cover property (dr_ev && pin_s2.shift && active == MODE_PEXTEST);
   c_ce_freeze: cover property (!ce ##1 ce);

endmodule

// file: tb.sv
// self-checking bench for the wrapper instruction decode block
`timescale 1ns/100ps
`include "cwd_params.svh"
module tb
   import cwd_pkg::*;
;
   typedef struct packed {
      logic [2:0] code;
      cwd_mode_t  md;
      logic       hold;
      logic [3:0] len;
      logic       par;
   } cwd_row_t;
   // unassigned codes are expected to act as bypass
   cwd_row_t rows [8] = '{
      '{`CWD_OP_BYPASS, MODE_BYPASS, 1'b0, `CWD_LEN_BYPASS, 1'b0},
      '{`CWD_OP_EXTEST, MODE_EXTEST, 1'b1, `CWD_LEN_BOUNDARY, 1'b0},
      '{`CWD_OP_INTEST, MODE_INTEST, 1'b0, `CWD_LEN_BOUNDARY, 1'b0},
      '{`CWD_OP_PEXTEST, MODE_PEXTEST, 1'b1, `CWD_LEN_BYPASS, 1'b1},
      '{3'h4, MODE_BYPASS, 1'b0, `CWD_LEN_BYPASS, 1'b0},
      '{3'h5, MODE_BYPASS, 1'b0, `CWD_LEN_BYPASS, 1'b0},
      '{3'h6, MODE_BYPASS, 1'b0, `CWD_LEN_BYPASS, 1'b0},
      '{3'h7, MODE_BYPASS, 1'b0, `CWD_LEN_BYPASS, 1'b0}};
   logic                 clk;
   logic                 rst_n;
   logic                 ce;
   logic                 wpi;
   logic [`CWD_NIN-1:0]  pin_in;
   logic [`CWD_NOUT-1:0] core_out;
   logic                 wrck;
   logic                 wrst_n;
   logic                 wsi;
   logic                 sel_wir;
   logic                 shift_wr;
   logic                 capture_wr;
   logic                 update_wr;
   logic                 wso;
   logic                 wpo;
   logic [`CWD_NOUT-1:0] wfo;
   logic [`CWD_NIN-1:0]  cfi;
   logic                 core_hold;
   logic                 par_en;
   cwd_mode_t            mode;
   logic [3:0]           path_len;
   logic [7:0]           pat;
   int                   num_errors = 0;
   int                   num_checks = 0;

   cwd_tam_model i_cwd_tam_model (.clk(clk), .wrck(wrck), .wrst_n(wrst_n), .wsi(wsi),
      .sel_wir(sel_wir), .shift_wr(shift_wr), .capture_wr(capture_wr), .update_wr(update_wr));
   cwd_wrapper_decode i_cwd_wrapper_decode (.clk(clk), .rst_n(rst_n), .ce(ce), .wrck(wrck),
      .wrst_n(wrst_n), .wsi(wsi), .sel_wir(sel_wir), .shift_wr(shift_wr),
      .capture_wr(capture_wr), .update_wr(update_wr), .wpi(wpi), .pin_in(pin_in),
      .core_out(core_out), .wso(wso), .wpo(wpo), .wfo(wfo), .cfi(cfi),
      .core_hold(core_hold), .par_en(par_en), .mode(mode), .path_len(path_len));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk_vec(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_vec(nm, {7'h00, e}, {7'h00, g});
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // the whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      wrap_up();
   end
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      wpi = 1'b0;
      pin_in = 4'h0;
      core_out = 4'h0;
      repeat (20) @(posedge clk);
      chk_vec("mode", 8'(MODE_BYPASS), 8'(mode));
      chk_vec("path_len", 8'(`CWD_LEN_BYPASS), 8'(path_len));
      chk_bit("core_hold", 1'b0, core_hold);
      rst_n <= 1'b1;
      i_cwd_tam_model.wreset();
      $display("reset test done");
      foreach (rows[i]) begin
         i_cwd_tam_model.load_ir(rows[i].code);
         chk_vec("mode", 8'(rows[i].md), 8'(mode));
         chk_bit("core_hold", rows[i].hold, core_hold);
         chk_vec("path_len", 8'(rows[i].len), 8'(path_len));
         chk_bit("par_en", rows[i].par, par_en);
         $display("row %0d done", i);
      end
      // shifting a new code must not disturb the active one until update
      i_cwd_tam_model.load_ir(`CWD_OP_EXTEST);
      for (int k = 0; k < 3; k++)
         i_cwd_tam_model.op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      chk_vec("mode", 8'(MODE_EXTEST), 8'(mode));
      i_cwd_tam_model.op(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      chk_vec("mode", 8'(MODE_BYPASS), 8'(mode));
      $display("update gating test done");
      i_cwd_tam_model.load_ir(`CWD_OP_EXTEST);
      pin_in <= 4'h6;
      pat = 8'hA5;
      for (int k = 0; k < 8; k++)
         i_cwd_tam_model.op(1'b0, 1'b1, 1'b0, 1'b0, pat[k]);
      i_cwd_tam_model.op(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      chk_vec("wfo", 8'h0A, 8'(wfo));
      chk_vec("cfi", 8'h06, 8'(cfi));
      chk_bit("core_hold", 1'b1, core_hold);
      i_cwd_tam_model.op(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      chk_vec("wfo", 8'h0A, 8'(wfo));
      chk_bit("wso", 1'b0, wso);
      pat = 8'h5D;
      for (int k = 0; k < 8; k++) begin
         i_cwd_tam_model.op(1'b0, 1'b1, 1'b0, 1'b0, pat[k]);
         chk_vec("wfo", 8'h0A, 8'(wfo));
         if (k < 3)
            chk_bit("wso", pin_in[k + 1], wso);
      end
      chk_bit("wso", pat[0], wso);
      i_cwd_tam_model.op(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      chk_vec("wfo", 8'h05, 8'(wfo));
      $display("external test done");
      // parallel instruction: boundary shifts from wpi, bypass bit stays on serial out
      i_cwd_tam_model.load_ir(`CWD_OP_PEXTEST);
      wpi <= 1'b1;
      i_cwd_tam_model.op(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      chk_bit("wpo", 1'b0, wpo);
      chk_bit("wso", 1'b0, wso);
      i_cwd_tam_model.op(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      chk_bit("wpo", pin_in[1], wpo);
      chk_bit("wso", 1'b1, wso);
      chk_vec("wfo", 8'h05, 8'(wfo));
      $display("parallel test done");
      i_cwd_tam_model.wreset();
      chk_vec("mode", 8'(MODE_BYPASS), 8'(mode));
      core_out <= 4'h9;
      pin_in <= 4'h3;
      for (int k = 0; k < 2; k++) begin
         i_cwd_tam_model.op(1'b0, 1'b1, 1'b0, 1'b0, k == 0);
         chk_bit("wso", k == 0, wso);
         chk_vec("wfo", 8'h09, 8'(wfo));
         chk_vec("cfi", 8'h03, 8'(cfi));
         chk_bit("wpo", 1'b0, wpo);
      end
      $display("bypass test done");
      // clock enable low freezes everything, so a whole op and a core change go unseen
      ce <= 1'b0;
      core_out <= 4'h4;
      i_cwd_tam_model.op(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      chk_bit("wso", 1'b0, wso);
      chk_vec("wfo", 8'h09, 8'(wfo));
      ce <= 1'b1;
      i_cwd_tam_model.op(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      chk_bit("wso", 1'b1, wso);
      chk_vec("wfo", 8'h04, 8'(wfo));
      $display("clock enable test done");
      wrap_up();
   end
endmodule
